//--- verilog/awcr_top.v
/*
 Wake-up configuration register block: interrupt-line select, keyboard and
 mouse wake options, key-table window, read-to-clear event status, and an
 Avalon-MM slave with waitrequest.
 Assumes key and mouse strobes come from keyboard-controller logic on the
 same clock; power-button and supply flags are pins and are synchronised.
*/
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`include "awcr_consts.vh"
module awcr_top #(
    parameter KEYS = `AWCR_KEYS_PER_SET
) (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire [9:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg [1:0] o_avs_response,
    input wire i_kb_valid,
    input wire [7:0] i_kb_code,
    input wire i_ms_move,
    input wire i_ms_left_click,
    input wire i_ms_right_click,
    input wire i_power_button_input_n,
    input wire i_standby_returned,
    input wire i_sys_power_was_on,
    input wire i_thermal_evt,
    input wire i_power_event_request,
    output reg [15:0] o_power_event_irq_lines,
    output reg o_swap_ports,
    output reg o_power_button_output_n,
    output reg o_wake,
    output reg o_irq
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire [2:0] pins_w;
    awcr_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_power_button_input_n, i_standby_returned, i_sys_power_was_on}),
        .o_sync(pins_w)
    );
    wire pb_in_n_w = pins_w[2];
    wire sb_ret_w = pins_w[1];
    wire pwr_on_w = pins_w[0];
    reg sb_ret_q;

    // ****************************************
    // Registers
    // ****************************************
    reg [3:0] irq_sel_q;
    reg [7:0] ctrl_q;
    reg [7:0] index_q;
    reg [7:0] status_q;
    reg track_q;
    reg [7:0] irq_stat_q;
    reg [7:0] irq_mask_q;
    reg [7:0] keys_q [0:3*KEYS-1];
    reg [7:0] key_data_spare_q;
    // Reset value is a whole byte; the select field keeps only its low nibble
    wire [7:0] irq_sel_rst_w = `AWCR_RST_IRQ_SEL;
    wire [8*KEYS-1:0] set0_w;
    wire [8*KEYS-1:0] incoming_w;
    wire kb_wake_w;
    genvar g;
    generate
        for (g = 0; g < KEYS; g = g + 1)
        begin : g_set0
            assign set0_w[g*8 +: 8] = keys_q[g];
        end
    endgenerate

    awcr_keyseq #(
        .KEYS(KEYS)
    ) u_keyseq (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_key_valid(i_kb_valid),
        .i_key_code(i_kb_code),
        .i_any_key(ctrl_q[`AWCR_CTL_KB_ANY]),
        .i_stored(set0_w),
        .o_incoming(incoming_w),
        .o_wake(kb_wake_w)
    );

    // ****************************************
    // Bus decode
    // ****************************************
    wire [7:0] idx_w = i_avs_address[9:2];
    // Only byte lane 0 carries a register
    wire lane_w = i_avs_byteenable[0];
    // Busy flag: a request still held during its answer cycle is not taken twice
    reg acc_q;
    wire take_w = (i_avs_read | i_avs_write) & ~acc_q;
    wire wr_w = take_w & i_avs_write & lane_w;
    wire rd_w = take_w & i_avs_read;
    wire hit_w = (idx_w == `AWCR_IDX_IRQ_SEL) || (idx_w == `AWCR_IDX_WAKE_CTRL) ||
                 (idx_w == `AWCR_IDX_KEY_INDEX) || (idx_w == `AWCR_IDX_KEY_DATA) ||
                 (idx_w == `AWCR_IDX_EVT_STATUS) || (idx_w == `AWCR_IDX_TRACK_CTRL) ||
                 (idx_w == `AWCR_IDX_IRQ_STATUS) || (idx_w == `AWCR_IDX_IRQ_MASK);

    // Key table window: set number and slot from the index
    wire [3:0] slot_w = index_q[3:0];
    wire slot_ok_w = slot_w <= `AWCR_SET_LAST;
    reg [1:0] win_w;
    always @*
    begin
        win_w = 2'd3;
        if (slot_ok_w)
        begin
            case (index_q[7:4])
                4'h0: win_w = 2'd0;
                4'h3: win_w = 2'd1;
                4'h4: win_w = 2'd2;
                default: win_w = 2'd3;
            endcase
        end
    end
    wire in_incoming_w = slot_ok_w && (index_q[7:4] == `AWCR_INCOMING_BASE >> 4);
    // Set number times set size plus slot, cut to the table's address width
    wire [31:0] entry_full_w = win_w * KEYS + slot_w;
    wire [5:0] entry_w = entry_full_w[5:0];
    reg [7:0] key_rd_w;
    always @*
    begin
        if (in_incoming_w)
        begin
            key_rd_w = incoming_w[slot_w*8 +: 8];
        end
        else if (win_w != 2'd3)
        begin
            key_rd_w = keys_q[entry_w];
        end
        else
        begin
            key_rd_w = key_data_spare_q;
        end
    end

    // ****************************************
    // Mouse wake qualification
    // ****************************************
    // Mouse wake needs enable bit 5 set; the button-select key is stored but unused
    reg ms_wake_w;
    always @*
    begin
        ms_wake_w = 1'b0;
        if (ctrl_q[`AWCR_CTL_MS_EN])
        begin
            if (ctrl_q[`AWCR_CTL_MS_ANY])
            begin
                ms_wake_w = i_ms_move | i_ms_left_click | i_ms_right_click;
            end
            else
            begin
                ms_wake_w = i_ms_left_click | i_ms_right_click;
            end
        end
    end

    // ****************************************
    // Standby return edge
    // ****************************************
    // Edges are ignored until the synchroniser has filled after reset, so a
    // supply that is already up does not pass for a fresh power cycle
    reg [1:0] settle_q;
    wire settled_w = (settle_q == 2'b11);
    wire sb_evt_w = settled_w & sb_ret_w & ~sb_ret_q;
    wire [7:0] evt_w = {2'b00, sb_evt_w, sb_evt_w & track_q & ~pwr_on_w, i_thermal_evt,
                        1'b0, ms_wake_w, kb_wake_w};

    // ****************************************
    // Register updates
    // ****************************************
    integer k;
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            acc_q <= 1'b0;
            irq_sel_q <= irq_sel_rst_w[3:0];
            ctrl_q <= `AWCR_RST_WAKE_CTRL;
            index_q <= `AWCR_RST_KEY_INDEX;
            status_q <= `AWCR_RST_EVT_STATUS;
            track_q <= 1'b0;
            settle_q <= 2'b00;
            irq_stat_q <= 8'h00;
            irq_mask_q <= 8'h00;
            key_data_spare_q <= `AWCR_RST_KEY_DATA;
            sb_ret_q <= 1'b0;
            o_avs_readdata <= 32'h00000000;
            o_avs_waitrequest <= 1'b1;
            o_avs_response <= 2'b00;
            for (k = 0; k < 3*KEYS; k = k + 1)
            begin
                keys_q[k] <= `AWCR_RST_KEY_DATA;
            end
        end
        else
        begin
            sb_ret_q <= sb_ret_w;
            if (!settled_w)
            begin
                settle_q <= settle_q + 2'b01;
            end
            acc_q <= take_w;
            o_avs_waitrequest <= ~take_w;
            if (take_w)
            begin
                o_avs_response <= hit_w ? 2'b00 : 2'b10;
            end
            if (wr_w)
            begin
                case (idx_w)
                    `AWCR_IDX_IRQ_SEL: irq_sel_q <= i_avs_writedata[3:0];
                    `AWCR_IDX_WAKE_CTRL: ctrl_q <= {i_avs_writedata[7:4], 1'b0, i_avs_writedata[2:0]};
                    `AWCR_IDX_KEY_INDEX: index_q <= i_avs_writedata[7:0];
                    `AWCR_IDX_KEY_DATA:
                    begin
                        if (win_w != 2'd3)
                        begin
                            keys_q[entry_w] <= i_avs_writedata[7:0];
                        end
                        else if (!in_incoming_w)
                        begin
                            key_data_spare_q <= i_avs_writedata[7:0];
                        end
                    end
                    `AWCR_IDX_TRACK_CTRL: track_q <= i_avs_writedata[7];
                    `AWCR_IDX_IRQ_MASK: irq_mask_q <= i_avs_writedata[7:0];
                    default: key_data_spare_q <= key_data_spare_q;
                endcase
            end
            // Set wins over the clear so an event in the read cycle is kept
            if (rd_w && idx_w == `AWCR_IDX_EVT_STATUS)
            begin
                status_q <= evt_w;
            end
            else
            begin
                status_q <= status_q | evt_w;
            end
            // Write-one-to-clear; an event in the same cycle keeps its bit set
            if (wr_w && idx_w == `AWCR_IDX_IRQ_STATUS)
            begin
                irq_stat_q <= (irq_stat_q & ~i_avs_writedata[7:0]) | evt_w;
            end
            else
            begin
                irq_stat_q <= irq_stat_q | evt_w;
            end
            o_avs_readdata <= 32'h00000000;
            if (rd_w)
            begin
                case (idx_w)
                    `AWCR_IDX_IRQ_SEL: o_avs_readdata[7:0] <= {4'h0, irq_sel_q};
                    `AWCR_IDX_WAKE_CTRL: o_avs_readdata[7:0] <= ctrl_q;
                    `AWCR_IDX_KEY_INDEX: o_avs_readdata[7:0] <= index_q;
                    `AWCR_IDX_KEY_DATA: o_avs_readdata[7:0] <= key_rd_w;
                    // Bit 4 forced low while tracking is off
                    `AWCR_IDX_EVT_STATUS: o_avs_readdata[7:0] <= status_q & {3'b111, track_q, 4'hF};
                    `AWCR_IDX_TRACK_CTRL: o_avs_readdata[7:0] <= {track_q, 7'h00};
                    `AWCR_IDX_IRQ_STATUS: o_avs_readdata[7:0] <= irq_stat_q;
                    `AWCR_IDX_IRQ_MASK: o_avs_readdata[7:0] <= irq_mask_q;
                    default: o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_power_event_irq_lines <= 16'h0000;
            o_swap_ports <= 1'b0;
            o_power_button_output_n <= 1'b1;
            o_wake <= 1'b0;
            o_irq <= 1'b0;
        end
        else
        begin
            o_power_event_irq_lines <= {15'h0000, i_power_event_request} << irq_sel_q;
            o_swap_ports <= ctrl_q[`AWCR_CTL_SWAP];
            // Blocked input counts as high; the output is wired-AND with wake whether blocked or not
            o_power_button_output_n <= (ctrl_q[`AWCR_CTL_PB_BLOCK] | pb_in_n_w) &
                                       ~(kb_wake_w | ms_wake_w);
            o_wake <= kb_wake_w | ms_wake_w;
            o_irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule

//--- verilog/awcr_consts.vh
/*
 Constants for the wake-up configuration register block: register offsets,
 field positions, reset values and key-table window bases.
 Assumes it is included by bare name from the design files.
*/
// Function
// - Low four bits choose event interrupt line
// - Any-event key set: click or movement wakes
// - Any-event key clear: left/right click wakes
// - Control bit 2 swaps keyboard/mouse ports
// - Any-key bit: any char, else sequence
// - Index selects stored key sets entries
// - Index 0x10-0x1E reads incoming keys
// - Data register accesses indexed character
// - Status bit 5 flags standby power cycle
// - Bit 4 reports pre-loss system power off
// - Tracking bit clear: bit 4 reads zero
// - Read-to-clear bits clear after read
// - Mouse wake status latched until read
`ifndef AWCR_CONSTS_VH
`define AWCR_CONSTS_VH

// ****************************************
// Register offsets (byte address = 4 x index)
// ****************************************
`define AWCR_IDX_IRQ_SEL 8'h70
`define AWCR_IDX_WAKE_CTRL 8'hE0
`define AWCR_IDX_KEY_INDEX 8'hE1
`define AWCR_IDX_KEY_DATA 8'hE2
`define AWCR_IDX_EVT_STATUS 8'hE3
`define AWCR_IDX_TRACK_CTRL 8'hF8
`define AWCR_IDX_IRQ_STATUS 8'hF9
`define AWCR_IDX_IRQ_MASK 8'hFA

// ****************************************
// Reset values
// ****************************************
`define AWCR_RST_IRQ_SEL 8'h00
`define AWCR_RST_WAKE_CTRL 8'h01
`define AWCR_RST_KEY_INDEX 8'h00
`define AWCR_RST_KEY_DATA 8'hFF
`define AWCR_RST_EVT_STATUS 8'h08

// ****************************************
// Field positions
// ****************************************
`define AWCR_CTL_KB_ANY 0
`define AWCR_CTL_MS_ANY 1
`define AWCR_CTL_SWAP 2
`define AWCR_CTL_MS_BTN 4
`define AWCR_CTL_MS_EN 5
`define AWCR_CTL_PB_BLOCK 7
`define AWCR_ST_KB_WAKE 0
`define AWCR_ST_MS_WAKE 1
`define AWCR_ST_THERMAL 3
`define AWCR_ST_PWR_OFF 4
`define AWCR_ST_SB_CYCLE 5

// ****************************************
// Key table windows
// ****************************************
`define AWCR_SET0_BASE 8'h00
`define AWCR_INCOMING_BASE 8'h10
`define AWCR_SET1_BASE 8'h30
`define AWCR_SET2_BASE 8'h40
`define AWCR_SET_LAST 4'hE
`define AWCR_KEYS_PER_SET 15
`endif

//--- verilog/awcr_sync.v
/*
 Two-flop synchroniser bank for pin inputs.
 Assumes one clock; the first stage feeds only the second.
*/
`timescale 1ns/10ps
module awcr_sync #(
    parameter WIDTH = 1
) (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule

//--- verilog/awcr_keyseq.v
/*
 Keyboard wake matcher: compares incoming characters against a stored
 sequence and records the incoming keystrokes.
 Assumes key strobes come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "awcr_consts.vh"
module awcr_keyseq #(
    parameter KEYS = 15
) (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_key_valid,
    input wire [7:0] i_key_code,
    input wire i_any_key,
    input wire [8*KEYS-1:0] i_stored,
    output reg [8*KEYS-1:0] o_incoming,
    output reg o_wake
);
    reg [3:0] pos_q;
    wire [7:0] expect_w;
    wire seq_end_w;
    assign expect_w = i_stored[pos_q*8 +: 8];
    // An 0xFF entry ends the stored sequence early, as erased entries do
    assign seq_end_w = (pos_q == KEYS - 1) || (i_stored[(pos_q+1)*8 +: 8] == 8'hFF);
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            pos_q <= 4'h0;
            o_wake <= 1'b0;
            o_incoming <= {8*KEYS{1'b1}};
        end
        else
        begin
            o_wake <= 1'b0;
            if (i_key_valid)
            begin
                o_incoming <= {o_incoming[8*KEYS-9:0], i_key_code};
                if (i_any_key)
                begin
                    o_wake <= 1'b1;
                end
                else if (i_key_code == expect_w)
                begin
                    if (seq_end_w)
                    begin
                        o_wake <= 1'b1;
                        pos_q <= 4'h0;
                    end
                    else
                    begin
                        pos_q <= pos_q + 4'h1;
                    end
                end
                else
                begin
                    pos_q <= 4'h0;
                end
            end
        end
    end
endmodule

//--- bench/awcr_monitor.sv
/* Port checker for the wake-up register block.
 Assumes one clock, 4 x index byte map, and writes to 0xE0 kept away from events. */
`timescale 1ns/10ps
module awcr_monitor (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire [9:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    input wire [31:0] o_avs_readdata,
    input wire o_avs_waitrequest,
    input wire [1:0] o_avs_response,
    input wire i_kb_valid,
    input wire i_ms_move,
    input wire i_ms_left_click,
    input wire i_power_event_request,
    input wire [15:0] o_power_event_irq_lines,
    input wire o_swap_ports,
    input wire o_wake
);
    // ****
    // Shadow of the wake control register
    // ****
    reg [7:0] ctl_q;
    wire acc = !o_avs_waitrequest;
    wire [7:0] idx = i_avs_address[9:2];
    always @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            ctl_q <= 8'h01;
        else if (acc && i_avs_write && idx == 8'hE0 && i_avs_byteenable[0])
            ctl_q <= i_avs_writedata[7:0];
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_irq_route: assert property (
        !$past(i_sys_rst) |-> $onehot0(o_power_event_irq_lines)
        && ((o_power_event_irq_lines != 16'h0000) == $past(i_power_event_request)))
        else $error("event line route wrong");
    a_swap_follow: assert property (
        acc && i_avs_write && idx == 8'hE0 && i_avs_byteenable[0] |=> o_swap_ports == $past(i_avs_writedata[2]))
        else $error("swap does not follow control");
    a_kb_any_wake: assert property (
        ctl_q[0] && i_kb_valid |-> ##[1:3] o_wake)
        else $error("any key gave no wake");
    a_ms_any_wake: assert property (
        ctl_q[5] && ctl_q[1] && i_ms_move |-> ##[1:3] o_wake)
        else $error("mouse move gave no wake");
    a_ms_click_wake: assert property (
        ctl_q[5] && !ctl_q[1] && i_ms_left_click |-> ##[1:3] o_wake)
        else $error("mouse click gave no wake");
    a_ack_one_cycle: assert property (
        $fell(o_avs_waitrequest) |=> o_avs_waitrequest)
        else $error("answer stood too long");
    a_ack_has_cause: assert property (
        acc |-> $past(i_avs_read || i_avs_write))
        else $error("answer without request");
    a_bad_index: assert property (
        acc && !(idx inside {8'h70, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hF8, 8'hF9, 8'hFA}) |-> o_avs_response == 2'h2)
        else $error("unmapped index not refused");
    a_ctl_readback: assert property (
        acc && i_avs_read && idx == 8'hE0 |-> o_avs_readdata == {24'h000000, ctl_q & 8'hF7})
        else $error("control readback wrong");
    cover property (acc && i_avs_write);
    cover property (o_wake);
    cover property (acc && o_avs_response == 2'h2);
endmodule
bind awcr_top awcr_monitor u_mon (.*);

//--- bench/awcr_kbc_model.sv
/* Keyboard-controller wake logic model: one-cycle key and mouse strobes.
 Assumes the block samples the strobes on the same rising edge. */
`timescale 1ns/10ps
module awcr_kbc_model (
    input wire i_ref_clk,
    output reg o_kb_valid,
    output reg [7:0] o_kb_code,
    output reg o_ms_move,
    output reg o_ms_left_click,
    output reg o_ms_right_click
);
    // ****
    // Strobes
    // ****
    initial
    begin
        o_kb_valid = 1'h0;
        o_kb_code = 8'h00;
        {o_ms_right_click, o_ms_left_click, o_ms_move} = 3'h0;
    end
    task send_key(input [7:0] code);
    begin
        @(posedge i_ref_clk);
        o_kb_valid <= 1'h1;
        o_kb_code <= code;
        @(posedge i_ref_clk);
        o_kb_valid <= 1'h0;
        // Inverted so a stale code can never pass for a real one
        o_kb_code <= ~code;
    end
    endtask
    task send_mouse(input [2:0] ev);
    begin
        @(posedge i_ref_clk);
        {o_ms_right_click, o_ms_left_click, o_ms_move} <= ev;
        @(posedge i_ref_clk);
        {o_ms_right_click, o_ms_left_click, o_ms_move} <= 3'h0;
    end
    endtask
endmodule

//--- bench/tb_acpi_wakeup_config_regs.sv
/* Self-checking bench for the wake-up register block.
 Assumes the one-cycle Avalon answer and the 4 x index byte map. */
`timescale 1ns/10ps
module tb_acpi_wakeup_config_regs;
    integer err_count = 0;
    integer total_checks = 0;
    integer seed = 37137;
    integer i;
    reg [7:0] v, k1, k2, sel, dummy;
    reg [7:0] kd [0:5];
    reg [1:0] rsp;
    reg seen;
    reg i_ref_clk = 1'h0, i_sys_rst = 1'h1, i_avs_read = 1'h0, i_avs_write = 1'h0, i_thermal_evt = 1'h0;
    reg i_power_button_input_n = 1'h1, i_standby_returned = 1'h0, i_sys_power_was_on = 1'h1;
    reg i_power_event_request = 1'h0;
    reg [9:0] i_avs_address = 10'h000;
    reg [31:0] i_avs_writedata = 32'h00000000;
    reg [3:0] i_avs_byteenable = 4'hF;
    wire i_kb_valid, i_ms_move, i_ms_left_click, i_ms_right_click;
    wire [7:0] i_kb_code;
    wire [31:0] o_avs_readdata;
    wire [1:0] o_avs_response;
    wire [15:0] o_power_event_irq_lines;
    wire o_avs_waitrequest, o_swap_ports, o_power_button_output_n, o_wake, o_irq;
    always #50 i_ref_clk = ~i_ref_clk;
    awcr_top dut (.*);
    awcr_kbc_model kbc (.i_ref_clk(i_ref_clk), .o_kb_valid(i_kb_valid), .o_kb_code(i_kb_code),
        .o_ms_move(i_ms_move), .o_ms_left_click(i_ms_left_click), .o_ms_right_click(i_ms_right_click));
    // ****
    // Tasks
    // ****
    task chk(input string name, input [31:0] e, input [31:0] g);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    end
    endtask
    task bus(input wr, input [7:0] idx, input [7:0] wd, output [7:0] rd);
    begin
        @(posedge i_ref_clk);
        i_avs_address <= {idx, 2'h0};
        i_avs_writedata <= {24'h000000, wd};
        i_avs_write <= wr;
        i_avs_read <= !wr;
        // Waits as long as the slave asks; only the watchdog ends a hang
        do
        begin
            @(posedge i_ref_clk);
        end
        while (o_avs_waitrequest !== 1'h0);
        rd = o_avs_readdata[7:0];
        rsp = o_avs_response;
        i_avs_write <= 1'h0;
        i_avs_read <= 1'h0;
    end
    endtask
    task wt(input [7:0] idx, input [7:0] d);
        bus(1'h1, idx, d, dummy);
    endtask
    task rc(input [7:0] idx, input [7:0] e);
    begin
        bus(1'h0, idx, 8'h00, v);
        chk($sformatf("register %h", idx), e, v);
    end
    endtask
    task see(input string name, input e, input integer n);
    begin
        seen = 1'h0;
        repeat (n)
        begin
            @(posedge i_ref_clk);
            seen = seen | o_wake;
        end
        chk(name, e, (n == 0) ? o_irq : seen);
    end
    endtask
    function [7:0] kidx(input integer j);
        kidx = ((j % 3 == 0) ? 8'h00 : (j % 3 == 1) ? 8'h30 : 8'h40) + ((j < 3) ? 8'h00 : 8'h0E);
    endfunction
    task test_done;
    begin
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    initial
    begin
        #1000000;
        err_count = err_count + 1;
        test_done;
    end
    // ****
    // Scenarios
    // ****
    initial
    begin
        repeat (4) @(posedge i_ref_clk);
        i_sys_rst <= 1'h0;
        rc(8'h70, 8'h00);
        rc(8'hE0, 8'h01);
        rc(8'hE1, 8'h00);
        rc(8'hE2, 8'hFF);
        rc(8'hE3, 8'h08);
        rc(8'hE3, 8'h00);
        rc(8'h71, 8'h00);
        chk("response", 2'h2, rsp);
        i_power_event_request <= 1'h1;
        for (i = 0; i < 8; i = i + 1)
        begin
            sel = (i < 2) ? {8{i[0]}} : $random(seed);
            wt(8'h70, sel);
            repeat (3) @(posedge i_ref_clk);
            chk("event lines", 16'h0001 << sel[3:0], o_power_event_irq_lines);
        end
        for (i = 0; i < 6; i = i + 1)
        begin
            kd[i] = $random(seed);
            wt(8'hE1, kidx(i));
            wt(8'hE2, kd[i]);
        end
        for (i = 0; i < 6; i = i + 1)
        begin
            wt(8'hE1, kidx(i));
            rc(8'hE2, kd[i]);
        end
        i_avs_byteenable <= 4'h0;
        wt(8'hE2, ~kd[5]);
        i_avs_byteenable <= 4'hF;
        rc(8'hE2, kd[5]);
        // Sequence mode: a stored pair ended by an empty entry
        wt(8'hE0, 8'h00);
        k1 = $random(seed) & 8'h7E;
        k2 = k1 + 8'h01;
        for (i = 0; i < 3; i = i + 1)
        begin
            wt(8'hE1, i[7:0]);
            wt(8'hE2, (i == 0) ? k1 : (i == 1) ? k2 : 8'hFF);
        end
        kbc.send_key(k2);
        see("wake", 1'h0, 6);
        kbc.send_key(k1);
        kbc.send_key(k2);
        see("wake", 1'h1, 6);
        wt(8'hE1, 8'h10);
        rc(8'hE2, k2);
        wt(8'hE1, 8'h11);
        rc(8'hE2, k1);
        wt(8'hE0, 8'h01);
        kbc.send_key(k1 ^ 8'h55);
        see("wake", 1'h1, 6);
        rc(8'hE3, 8'h01);
        wt(8'hE0, 8'h22);
        kbc.send_mouse(3'h1);
        see("wake", 1'h1, 6);
        rc(8'hE3, 8'h02);
        rc(8'hE3, 8'h00);
        wt(8'hE0, 8'h20);
        kbc.send_mouse(3'h1);
        see("wake", 1'h0, 6);
        kbc.send_mouse(3'h2);
        see("wake", 1'h1, 6);
        rc(8'hE3, 8'h02);
        wt(8'hE0, 8'h02);
        kbc.send_mouse(3'h4);
        see("wake", 1'h0, 6);
        i_power_button_input_n <= 1'h0;
        wt(8'hE0, 8'h04);
        repeat (5) @(posedge i_ref_clk);
        chk("swap", 1'h1, o_swap_ports);
        chk("button", 1'h0, o_power_button_output_n);
        wt(8'hE0, 8'h80);
        repeat (3) @(posedge i_ref_clk);
        chk("swap", 1'h0, o_swap_ports);
        chk("button", 1'h1, o_power_button_output_n);
        i_power_button_input_n <= 1'h1;
        // Standby cycles: tracked off, tracked on, untracked off
        for (i = 0; i < 3; i = i + 1)
        begin
            wt(8'hF8, (i < 2) ? 8'h80 : 8'h00);
            i_sys_power_was_on <= (i == 1);
            i_standby_returned <= 1'h0;
            repeat (6) @(posedge i_ref_clk);
            i_standby_returned <= 1'h1;
            repeat (6) @(posedge i_ref_clk);
            rc(8'hE3, (i == 0) ? 8'h30 : 8'h20);
        end
        rc(8'hE3, 8'h00);
        wt(8'hF9, 8'hFF);
        wt(8'hFA, 8'h08);
        i_thermal_evt <= 1'h1;
        @(posedge i_ref_clk);
        i_thermal_evt <= 1'h0;
        repeat (3) @(posedge i_ref_clk);
        see("irq", 1'h1, 0);
        wt(8'hFA, 8'h00);
        repeat (2) @(posedge i_ref_clk);
        see("irq", 1'h0, 0);
        wt(8'hFA, 8'h08);
        repeat (2) @(posedge i_ref_clk);
        see("irq", 1'h1, 0);
        wt(8'hF9, 8'h08);
        repeat (2) @(posedge i_ref_clk);
        see("irq", 1'h0, 0);
        test_done;
    end
endmodule
